//--- rtl/ptp_pkg.sv
// constants and lookup functions shared by the power-to-pulse converter
package ptp_pkg;

    // ****************************************************************
    // clock and data widths
    // ****************************************************************
    localparam longint CLK_HZ = 40_000_000;
    localparam int PWR_W = 24;
    localparam int SUM_W = 26;
    localparam int ACC_W = 40;
    localparam int SEL_W = 3;
    localparam int DIV_W = 20;
    localparam int SYNC_N = 5;

    // ****************************************************************
    // per-phase low-pass filter
    // ****************************************************************
    localparam longint LPF_CORNER_HZ = 8;
    localparam int LPF_SHIFT = 10;
    localparam longint TWO_PI_MILLI = 6283;
    // update rate = 2*pi*corner*2^shift puts the single pole at the corner
    localparam longint LPF_DIV_L =
        (CLK_HZ * 1000) / (TWO_PI_MILLI * LPF_CORNER_HZ * (64'(1) << LPF_SHIFT));
    localparam logic [DIV_W-1:0] LPF_DIV = DIV_W'(LPF_DIV_L);

    // ****************************************************************
    // transfer function
    // ****************************************************************
    localparam longint TICKS_PER_BASE = 1024;
    localparam longint FULL_SCALE = 64'(1) << (PWR_W - 1);
    localparam longint GAIN_MILLI = 6313;
    localparam longint VREF_SQ_CENTI = 576;
    // full-scale input is 0.5 V on each channel, so the product is 1/4 V^2
    localparam longint FS_PRODUCT_INV = 4;
    localparam longint ENERGY_THRESH_L = (TICKS_PER_BASE * FULL_SCALE * VREF_SQ_CENTI
        * FS_PRODUCT_INV * 1000) / (100 * GAIN_MILLI);
    localparam logic [ACC_W-1:0] ENERGY_THRESH = ACC_W'(ENERGY_THRESH_L);

    // creep guard: a phase below this magnitude counts as unloaded
    localparam logic [PWR_W:0] NO_LOAD_LEVEL = 25'h0000800;

    // ****************************************************************
    // output pulse widths
    // ****************************************************************
    localparam longint ENERGY_PULSE_MS = 100;
    localparam longint CAL_PULSE_US = 500;
    localparam int unsigned ENERGY_PULSE_CYC = int'(ENERGY_PULSE_MS * CLK_HZ / 1000);
    localparam int unsigned CAL_PULSE_CYC = int'(CAL_PULSE_US * CLK_HZ / 1_000_000);
    localparam int PW_W = 23;

    // base rate in hundredths of a hertz, index {scale, bit1, bit0}
    function automatic longint ptp_base_centi(input logic [SEL_W-1:0] code);
        case (code)
            3'h0: ptp_base_centi = 224;
            3'h1: ptp_base_centi = 112;
            3'h2: ptp_base_centi = 509;
            3'h3: ptp_base_centi = 56;
            3'h4: ptp_base_centi = 449;
            3'h5: ptp_base_centi = 449;
            3'h6: ptp_base_centi = 112;
            default: ptp_base_centi = 56;
        endcase
    endfunction : ptp_base_centi

    // master clock cycles per accumulation tick
    function automatic logic [DIV_W-1:0] ptp_rate_div(input logic [SEL_W-1:0] code);
        ptp_rate_div = DIV_W'((CLK_HZ * 100) / (ptp_base_centi(code) * TICKS_PER_BASE));
    endfunction : ptp_rate_div

    // calibration output runs this many times faster than the energy outputs
    function automatic longint ptp_cal_mult(input logic [SEL_W-1:0] code);
        case (code)
            3'h0: ptp_cal_mult = 16;
            3'h1: ptp_cal_mult = 32;
            3'h2: ptp_cal_mult = 160;
            3'h3: ptp_cal_mult = 32;
            3'h4: ptp_cal_mult = 8;
            default: ptp_cal_mult = 16;
        endcase
    endfunction : ptp_cal_mult

    function automatic logic [ACC_W-1:0] ptp_cal_thresh(input logic [SEL_W-1:0] code);
        ptp_cal_thresh = ACC_W'(ENERGY_THRESH_L / ptp_cal_mult(code));
    endfunction : ptp_cal_thresh

endpackage : ptp_pkg

//--- rtl/ptp_lpf.sv
// single-pole low-pass filter for one phase's power product
`timescale 1ns/1ps
module ptp_lpf (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic signed [ptp_pkg::PWR_W-1:0] x_i,
    output logic signed [ptp_pkg::PWR_W-1:0] y_o
);
    localparam int SW = ptp_pkg::PWR_W + ptp_pkg::LPF_SHIFT + 1;

    logic signed [SW-1:0] state;
    logic signed [SW-1:0] next_state;

    // state holds y scaled by 2^shift, so the leak is a plain shift
    always_comb begin
        next_state = state + SW'(x_i) - (state >>> ptp_pkg::LPF_SHIFT); // RQ1
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= '0;
        end else if (en_i) begin
            state <= next_state; // RQ1
        end
    end

    assign y_o = ptp_pkg::PWR_W'(state >>> ptp_pkg::LPF_SHIFT);

    // ****************************************************************
    // checks
    // ****************************************************************
    a_lpf_step: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ1
        en_i |=> state == $past(state) + SW'($past(x_i))
        - ($past(state) >>> ptp_pkg::LPF_SHIFT))
        else $error("filter state did not take one leaky step");
    a_lpf_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ1
        !en_i |=> $stable(state))
        else $error("filter moved without an update enable");

endmodule : ptp_lpf

//--- rtl/ptp_converter.sv
// three-phase power summing and power-to-pulse conversion
`timescale 1ns/1ps
// How it works
// RQ1: each phase product passes a single-pole low-pass with its corner at 8 Hz.
// RQ2: filtered power accumulates continuously; each threshold crossing emits one pulse.
// RQ3: calibration accumulator uses a smaller threshold, up to 160 times faster.
// RQ4: sum mode high adds signed phase powers, low adds their magnitudes.
// RQ5: in magnitude mode every phase counts positive; accumulation stops only when all phases are unloaded.
// RQ6: negative flag follows the sign of the signed three-phase sum in both modes.
// RQ7: negative flag changes only together with a calibration pulse, or clears at once when all phases are unloaded.
// RQ8: negative flag stays set until sum turns positive or all phases unloaded.
// RQ9: both energy outputs carry the energy as active-high pulses.
// RQ10: three select pins pick one of eight table entries, which hold five distinct base rates.
// RQ11: every base rate is a division of the master clock.
// RQ12: energy rate is 6.313 times power sum times base rate over Vref squared.
// RQ13: full-scale ac at select 010 gives at most 2.09 Hz energy pulses.
// RQ14: full-scale ac gives half the energy pulse rate of full-scale dc.
// RQ15: the far side averages the calibration pulse rate to remove ripple.
// RQ16: while supply is not good, accumulators and outputs stay reset, no pulses.
// RQ17: every output pulse has a fixed width shorter than its shortest period.
module ptp_converter #(
    parameter int unsigned ENERGY_PULSE_CYC = ptp_pkg::ENERGY_PULSE_CYC,
    parameter int unsigned CAL_PULSE_CYC = ptp_pkg::CAL_PULSE_CYC,
    // scales both thresholds down together for short runs; the ratio between them is kept
    parameter int unsigned THRESH_SHIFT = 0
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic supply_ok_i,
    input wire logic sum_mode_select_i,
    input wire logic rate_scale_select_i,
    input wire logic rate_select_bit1_i,
    input wire logic rate_select_bit0_i,
    input wire logic signed [ptp_pkg::PWR_W-1:0] phase_power_a_i,
    input wire logic signed [ptp_pkg::PWR_W-1:0] phase_power_b_i,
    input wire logic signed [ptp_pkg::PWR_W-1:0] phase_power_c_i,
    output logic energy_pulse_out_first_o,
    output logic energy_pulse_out_second_o,
    output logic calibration_pulse_out_o,
    output logic negative_power_flag_o
);
    localparam int PW = ptp_pkg::PWR_W;
    localparam int SW = ptp_pkg::SUM_W;
    localparam int AW = ptp_pkg::ACC_W;
    localparam int DW = ptp_pkg::DIV_W;
    localparam int NS = ptp_pkg::SYNC_N;

    // ****************************************************************
    // pin synchronisers: a change counts once stages two and three agree
    // ****************************************************************
    logic [NS-1:0] pins;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] sync3;
    logic [NS-1:0] pin_ok;

    assign pins = {supply_ok_i, sum_mode_select_i, rate_scale_select_i,
                   rate_select_bit1_i, rate_select_bit0_i};

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_ok <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < NS; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_ok[i] <= sync3[i];
                end
            end
        end
    end

    logic hold;
    logic arith_mode;
    logic [ptp_pkg::SEL_W-1:0] rate_code;

    // supply monitor low keeps the whole data path in reset
    assign hold = rst_i | ~pin_ok[4]; // RQ16
    assign arith_mode = pin_ok[3];
    assign rate_code = pin_ok[2:0]; // RQ10

    // ****************************************************************
    // dividers: filter update and accumulation tick
    // ****************************************************************
    logic [DW-1:0] lpf_cnt;
    logic lpf_en;
    logic [DW-1:0] tick_cnt;
    logic [DW-1:0] tick_max;
    logic tick;

    assign tick_max = ptp_pkg::ptp_rate_div(rate_code) - DW'(1); // RQ11

    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            lpf_cnt <= '0;
            lpf_en <= 1'b0;
        end else begin
            lpf_en <= (lpf_cnt == ptp_pkg::LPF_DIV - DW'(1));
            lpf_cnt <= (lpf_cnt == ptp_pkg::LPF_DIV - DW'(1)) ? '0 : lpf_cnt + DW'(1);
        end
    end

    // a rate change applies to the count in progress, and wraps at once if the count is past the new limit
    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt >= tick_max); // RQ11
            tick_cnt <= (tick_cnt >= tick_max) ? '0 : tick_cnt + DW'(1);
        end
    end

    // ****************************************************************
    // filtering and summing
    // ****************************************************************
    logic signed [PW-1:0] filt_a;
    logic signed [PW-1:0] filt_b;
    logic signed [PW-1:0] filt_c;

    ptp_lpf u_lpf_a (.clk_sys_i(clk_sys_i), .rst_i(hold), .en_i(lpf_en),
                     .x_i(phase_power_a_i), .y_o(filt_a));
    ptp_lpf u_lpf_b (.clk_sys_i(clk_sys_i), .rst_i(hold), .en_i(lpf_en),
                     .x_i(phase_power_b_i), .y_o(filt_b));
    ptp_lpf u_lpf_c (.clk_sys_i(clk_sys_i), .rst_i(hold), .en_i(lpf_en),
                     .x_i(phase_power_c_i), .y_o(filt_c));

    logic [PW:0] mag_a;
    logic [PW:0] mag_b;
    logic [PW:0] mag_c;
    logic signed [SW-1:0] sum_signed;
    logic [SW-1:0] sum_mag;
    logic [SW-1:0] abs_sum;
    logic [SW-1:0] inc;
    logic no_load;

    assign mag_a = filt_a[PW-1] ? (PW+1)'(-filt_a) : (PW+1)'(filt_a);
    assign mag_b = filt_b[PW-1] ? (PW+1)'(-filt_b) : (PW+1)'(filt_b);
    assign mag_c = filt_c[PW-1] ? (PW+1)'(-filt_c) : (PW+1)'(filt_c);
    assign sum_signed = SW'(filt_a) + SW'(filt_b) + SW'(filt_c); // RQ6
    assign sum_mag = sum_signed[SW-1] ? SW'(-sum_signed) : SW'(sum_signed);
    assign abs_sum = SW'(mag_a) + SW'(mag_b) + SW'(mag_c); // RQ5
    assign inc = arith_mode ? sum_mag : abs_sum; // RQ4
    assign no_load = (mag_a < ptp_pkg::NO_LOAD_LEVEL) && (mag_b < ptp_pkg::NO_LOAD_LEVEL)
                  && (mag_c < ptp_pkg::NO_LOAD_LEVEL);

    // ****************************************************************
    // accumulators
    // ****************************************************************
    logic [AW-1:0] acc_e;
    logic [AW-1:0] acc_c;
    logic [AW-1:0] cal_thresh;
    logic [AW-1:0] energy_thresh;
    logic [AW-1:0] next_acc_e;
    logic [AW-1:0] next_acc_c;
    logic energy_ev;
    logic cal_ev;

    // threshold is set so full-scale dc gives 6.313*0.75*f/5.76 pulses per second
    assign energy_thresh = ptp_pkg::ENERGY_THRESH >> THRESH_SHIFT; // RQ12 RQ13 RQ14
    assign cal_thresh = ptp_pkg::ptp_cal_thresh(rate_code) >> THRESH_SHIFT; // RQ3
    assign next_acc_e = acc_e + AW'(inc); // RQ12
    assign next_acc_c = acc_c + AW'(inc);

    // the threshold is subtracted, not cleared, so no energy is lost at a pulse
    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            acc_e <= '0;
            acc_c <= '0;
            energy_ev <= 1'b0;
            cal_ev <= 1'b0;
        end else if (tick && !no_load) begin
            energy_ev <= (next_acc_e >= energy_thresh); // RQ2
            acc_e <= (next_acc_e >= energy_thresh) ?
                     next_acc_e - energy_thresh : next_acc_e; // RQ2
            cal_ev <= (next_acc_c >= cal_thresh); // RQ3
            acc_c <= (next_acc_c >= cal_thresh) ? next_acc_c - cal_thresh : next_acc_c;
        end else begin
            energy_ev <= 1'b0;
            cal_ev <= 1'b0;
        end
    end

    // ****************************************************************
    // pulse stretchers and negative-power flag
    // ****************************************************************
    logic [ptp_pkg::PW_W-1:0] e_cnt;
    logic [ptp_pkg::PW_W-1:0] c_cnt;

    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            e_cnt <= '0;
            energy_pulse_out_first_o <= 1'b0; // RQ16
            energy_pulse_out_second_o <= 1'b0;
        end else if (energy_ev) begin
            e_cnt <= ptp_pkg::PW_W'(ENERGY_PULSE_CYC - 1); // RQ17
            energy_pulse_out_first_o <= 1'b1; // RQ9
            energy_pulse_out_second_o <= 1'b1; // RQ9
        end else if (e_cnt != '0) begin
            e_cnt <= e_cnt - ptp_pkg::PW_W'(1);
        end else begin
            energy_pulse_out_first_o <= 1'b0;
            energy_pulse_out_second_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            c_cnt <= '0;
            calibration_pulse_out_o <= 1'b0; // RQ16
        end else if (cal_ev) begin
            c_cnt <= ptp_pkg::PW_W'(CAL_PULSE_CYC - 1); // RQ17
            calibration_pulse_out_o <= 1'b1;
        end else if (c_cnt != '0) begin
            c_cnt <= c_cnt - ptp_pkg::PW_W'(1);
        end else begin
            calibration_pulse_out_o <= 1'b0;
        end
    end

    // no calibration pulse comes under no load, so that clear is immediate
    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            negative_power_flag_o <= 1'b0;
        end else if (no_load) begin
            negative_power_flag_o <= 1'b0; // RQ8
        end else if (cal_ev) begin
            negative_power_flag_o <= sum_signed[SW-1]; // RQ6 RQ7
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_cal_event;
        cal_ev && !no_load;
    endsequence

    a_flag_sign: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ6
        s_cal_event |=> negative_power_flag_o == $past(sum_signed[SW-1]))
        else $error("negative flag does not follow the signed sum");
    a_flag_timing: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ7
        $changed(negative_power_flag_o) |-> $past(cal_ev) || $past(no_load))
        else $error("negative flag changed away from a calibration pulse");
    a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ8
        negative_power_flag_o && !cal_ev && !no_load |=> negative_power_flag_o)
        else $error("negative flag dropped without cause");
    a_hold_quiet: assert property (@(posedge clk_sys_i) // RQ16
        hold |=> !energy_pulse_out_first_o && !calibration_pulse_out_o && acc_e == '0)
        else $error("outputs active while supply not good");
    a_energy_pair: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ9
        energy_pulse_out_first_o == energy_pulse_out_second_o)
        else $error("energy outputs disagree");
    a_energy_wrap: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ2
        tick && !no_load && next_acc_e >= energy_thresh |=> energy_ev ##1
        energy_pulse_out_first_o)
        else $error("threshold crossing gave no energy pulse");
    a_cal_faster: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ3
        cal_thresh < energy_thresh)
        else $error("calibration threshold not below energy threshold");
    a_mode_inc: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ4 RQ5
        inc >= sum_mag && (!arith_mode || inc == sum_mag))
        else $error("increment does not match sum mode");
    a_cal_width: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ17
        $rose(calibration_pulse_out_o) |-> c_cnt == ptp_pkg::PW_W'(CAL_PULSE_CYC - 1))
        else $error("calibration pulse width counter mis-loaded");
    a_cal_end: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ17
        calibration_pulse_out_o && c_cnt == '0 && !cal_ev |=> !calibration_pulse_out_o)
        else $error("calibration pulse overran its width");
    a_tick_div: assert property (@(posedge clk_sys_i) disable iff (hold) // RQ11
        tick |-> tick_cnt == '0 ##1 !tick)
        else $error("tick divider out of step");

endmodule : ptp_converter

//--- test/ptp_pulse_counter.sv
// far-side model: a pulse counter that times and cross-checks the converter outputs
`timescale 1ns/1ps
module ptp_pulse_counter #(
    parameter int unsigned ENERGY_PULSE_CYC = 8,
    parameter int unsigned CAL_PULSE_CYC = 4
) (
    input wire logic clk_sys_i,
    input wire logic energy_first_i,
    input wire logic energy_second_i,
    input wire logic cal_i,
    input wire logic flag_i,
    input wire logic neg_expect_i,
    output int cal_count_o,
    output int energy_count_o,
    output int mism_o
);
    int cal_wid;
    int en_wid;
    logic cal_q;
    logic en_q;
    logic flag_q;

    initial begin
        cal_count_o = 0;
        energy_count_o = 0;
        mism_o = 0;
        cal_wid = 0;
        en_wid = 0;
        cal_q = 1'b0;
        en_q = 1'b0;
        flag_q = 1'b0;
    end

    // ****************************************************************
    // pulse counting and width timing
    // ****************************************************************
    // counts are cumulative so the rate is averaged over a whole test window
    always @(posedge clk_sys_i) begin
        if (energy_first_i !== energy_second_i) begin
            mism_o++;
            $display("mismatch energy outputs differ expected %b seen %b",
                energy_first_i, energy_second_i);
        end
        if (cal_i === 1'b1 && cal_q === 1'b0) begin
            cal_count_o++;
            if (flag_i !== neg_expect_i) begin
                mism_o++;
                $display("mismatch flag at cal pulse expected %b seen %b", neg_expect_i, flag_i);
            end
        end
        // a flag rise is legal only together with a calibration rise
        if (flag_i === 1'b1 && flag_q === 1'b0 && !(cal_i === 1'b1 && cal_q === 1'b0)) begin
            mism_o++;
            $display("mismatch flag rose without cal pulse expected %b seen %b", 1'b0, flag_i);
        end
        if (cal_i === 1'b1) cal_wid++;
        if (cal_q === 1'b1 && cal_i === 1'b0) begin
            if (cal_wid != int'(CAL_PULSE_CYC)) begin
                mism_o++;
                $display("mismatch cal width expected %0d seen %0d", CAL_PULSE_CYC, cal_wid);
            end
            cal_wid = 0;
        end
        if (energy_first_i === 1'b1) en_wid++;
        if (en_q === 1'b0 && energy_first_i === 1'b1) energy_count_o++;
        if (en_q === 1'b1 && energy_first_i === 1'b0) begin
            if (en_wid != int'(ENERGY_PULSE_CYC)) begin
                mism_o++;
                $display("mismatch energy width expected %0d seen %0d", ENERGY_PULSE_CYC, en_wid);
            end
            en_wid = 0;
        end
        cal_q = cal_i;
        en_q = energy_first_i;
        flag_q = flag_i;
    end
endmodule : ptp_pulse_counter

//--- test/ptp_converter_bench.sv
// self-checking testbench for the power-to-pulse converter
`timescale 1ns/1ps
module ptp_converter_bench;
    localparam int unsigned EPW = 8;
    localparam int unsigned CPW = 4;
    // thresholds scaled down by 2^15 so both pulse kinds come within the run
    localparam int unsigned TSH = 15;
    localparam int TIMEOUT = 90000;

    logic clk_sys_i;
    logic rst_i;
    logic supply_ok_i;
    logic sum_mode;
    logic [2:0] code;
    logic signed [ptp_pkg::PWR_W-1:0] pwr;
    logic f1;
    logic f2;
    logic cf;
    logic flag;
    logic neg_expect;
    int cal_count;
    int energy_count;
    int mism;
    int errors;
    int checked;
    int cycles;

    ptp_converter #(.ENERGY_PULSE_CYC(EPW), .CAL_PULSE_CYC(CPW), .THRESH_SHIFT(TSH)) dut (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .supply_ok_i(supply_ok_i),
        .sum_mode_select_i(sum_mode),
        .rate_scale_select_i(code[2]),
        .rate_select_bit1_i(code[1]),
        .rate_select_bit0_i(code[0]),
        .phase_power_a_i(pwr),
        .phase_power_b_i(pwr),
        .phase_power_c_i(pwr),
        .energy_pulse_out_first_o(f1),
        .energy_pulse_out_second_o(f2),
        .calibration_pulse_out_o(cf),
        .negative_power_flag_o(flag)
    );

    ptp_pulse_counter #(.ENERGY_PULSE_CYC(EPW), .CAL_PULSE_CYC(CPW)) counter (
        .clk_sys_i(clk_sys_i),
        .energy_first_i(f1),
        .energy_second_i(f2),
        .cal_i(cf),
        .flag_i(flag),
        .neg_expect_i(neg_expect),
        .cal_count_o(cal_count),
        .energy_count_o(energy_count),
        .mism_o(mism)
    );

    // ****************************************************************
    // clock and timeout
    // ****************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    initial cycles = 0;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            errors++;
            test_done();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_num(input string what, input int exp, input int got);
        checked++;
        if (got != exp) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num

    task automatic set_pins(input logic ok, input logic signed_sum, input logic [2:0] sel);
        @(negedge clk_sys_i);
        supply_ok_i = ok;
        sum_mode = signed_sum;
        code = sel;
    endtask : set_pins

    task automatic run(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask : run

    task automatic check_idle(input string what);
        check_bit({what, " first"}, 1'b0, f1);
        check_bit({what, " second"}, 1'b0, f2);
        check_bit({what, " cal"}, 1'b0, cf);
        check_bit({what, " flag"}, 1'b0, flag);
    endtask : check_idle

    task automatic test_done;
        errors = errors + mism;
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        errors = 0;
        checked = 0;
        rst_i = 1'b1;
        supply_ok_i = 1'b0;
        sum_mode = 1'b1;
        code = 3'h0;
        pwr = 24'sh000000;
        neg_expect = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check_idle("reset");
        rst_i = 1'b0;
        // full-scale load while the supply is still bad
        pwr = 24'sh7FFFFF;
        set_pins(1'b0, 1'b1, 3'h2);
        run(10000);
        check_idle("hold");
        check_num("cal pulses in hold", 0, cal_count);
        check_num("energy pulses in hold", 0, energy_count);
        // no load on any phase at every rate code
        pwr = 24'sh000000;
        for (int i = 0; i < 8; i++) begin
            set_pins(1'b1, i[0], 3'(i));
            run(2000);
            check_bit("no load flag", 1'b0, flag);
            check_num("no load cal pulses", 0, cal_count);
        end
        // reverse power on all phases, signed then magnitude sum
        neg_expect = 1'b1;
        pwr = 24'sh800001;
        set_pins(1'b1, 1'b1, 3'h2);
        run(25000);
        check_bit("signed mode flag", 1'b1, flag);
        check_bit("cal pulses seen", 1'b1, logic'(cal_count > 0));
        set_pins(1'b1, 1'b0, 3'h2);
        run(20000);
        check_bit("magnitude mode flag", 1'b1, flag);
        check_bit("energy pulses seen", 1'b1, logic'(energy_count > 0));
        check_bit("cal faster than energy", 1'b1, logic'(cal_count > energy_count));
        // supply drop in mid-run, between pulses so none is cut short
        @(posedge cf);
        wait (cf === 1'b0 && f1 === 1'b0);
        set_pins(1'b0, 1'b0, 3'h2);
        run(8);
        check_idle("supply drop");
        set_pins(1'b1, 1'b1, 3'h3);
        run(200);
        // second reset in mid-run
        rst_i = 1'b1;
        run(1);
        check_idle("second reset");
        rst_i = 1'b0;
        run(50);
        check_bit("after reset flag", 1'b0, flag);
        test_done();
    end
endmodule : ptp_converter_bench
